// [rtl/pcl_pkg.sv]
// Shared constants, register layout and check-sequence helpers.
// Assumes byte-wide registers on a simple address/strobe register port.
package pcl_pkg;
	localparam logic [7:0] ADDR_LAYOUT  = 8'h04;
	localparam logic [7:0] ADDR_CFG     = 8'h05;
	localparam logic [7:0] ADDR_RES_H   = 8'h13;
	localparam logic [7:0] ADDR_RES_M   = 8'h14;
	localparam logic [7:0] ADDR_RES_L   = 8'h15;
	localparam logic [7:0] ADDR_STATUS  = 8'h16;
	localparam logic [7:0] ADDR_TXLEN_H = 8'h7a;
	localparam logic [7:0] ADDR_TXLEN_L = 8'h7b;
	localparam logic [7:0] CFG_RESET    = 8'h1c;
	localparam logic [1:0] LAYOUT_RESET = 2'h0;

	localparam logic [1:0] WID_8        = 2'h0;
	localparam logic [1:0] WID_16       = 2'h1;
	localparam logic [1:0] WID_32       = 2'h2;
	localparam logic [1:0] LEN_MODE_2   = 2'h1;
	localparam logic [1:0] LAYOUT_GEN   = 2'h2;
	localparam int         LEN_HI_BITS  = 3;
	localparam int         LEN_W        = 8 + LEN_HI_BITS;

	localparam int         ST_ACC_ERR   = 0;
	localparam int         ST_RX_ERR    = 1;
	localparam int         ST_TX_BUSY   = 2;
	localparam int         ST_RX_BUSY   = 3;

	localparam logic [7:0]  POLY8       = 8'h07;
	localparam logic [15:0] POLY16      = 16'h1021;
	localparam logic [31:0] POLY32      = 32'h04c11db7;
	localparam logic [5:0]  CRC_MAX     = 6'h20;

	typedef struct packed {
		logic       seedOnes;
		logic       compOff;
		logic [1:0] checkWidthSelect;
		logic       rxCheckEn;
		logic       txAppendEn;
		logic [1:0] lenMode;
	} pcl_cfg_t;

	// Widths 8 and 32 fall back to 16 outside the general-purpose layout.
	function automatic logic [1:0] pcl_eff_width(input logic [1:0] w,
			input logic [1:0] layout);
		if (w == WID_16 || (layout == LAYOUT_GEN && w != 2'h3))
			return w;
		return WID_16;
	endfunction

	function automatic logic [5:0] pcl_bits(input logic [1:0] w);
		case (w)
			WID_8:   return 6'h08;
			WID_32:  return 6'h20;
			default: return 6'h10;
		endcase
	endfunction

	function automatic logic [31:0] pcl_poly(input logic [1:0] w);
		case (w)
			WID_8:   return {POLY8, 24'h0};
			WID_32:  return POLY32;
			default: return {POLY16, 16'h0};
		endcase
	endfunction

	// Check register is kept top-aligned, MSB first.
	function automatic logic [31:0] pcl_crc_byte(input logic [31:0] crc,
			input logic [7:0] d, input logic [31:0] poly);
		logic [31:0] c;
		c = crc ^ {d, 24'h0};
		for (int i = 0; i < 8; i++) begin
			c = c[31] ? ((c << 1) ^ poly) : (c << 1);
		end
		return c;
	endfunction
endpackage

// [rtl/pcl_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; flags are registered.
`timescale 1ns/1ns
module pcl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst,
	// Fill side.
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Drain side.
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_ff;
	logic [AW-1:0]    rdPtr_ff;
	logic [AW:0]      count_ff;
	logic [AW:0]      nxt_count;
	logic             push;
	logic             pop;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr_ff];

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop)
			nxt_count = count_ff + 1'b1;
		else if (pop && !push)
			nxt_count = count_ff - 1'b1;
	end

	always_ff @(posedge clock) begin
		if (push)
			mem[wrPtr_ff] <= inData;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
			inReady  <= 1'b0;
			outValid <= 1'b0;
		end else begin
			if (push)
				wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
			if (pop)
				rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
			count_ff <= nxt_count;
			inReady  <= nxt_count != (AW + 1)'(DEPTH);
			outValid <= nxt_count != '0;
		end
	end
endmodule

// [rtl/pcl_engine.sv]
// Packet check-sequence and length engine with its configuration registers.
// Assumes host and modem byte streams are logic on the same clock.
//
// Function
// - The check register starts at all zeros or all ones per the seed bit.
// - The final check value is complemented unless complement-off is set.
// - The width field picks 8, 16 or 32 bits; 8/32 only in general layout.
// - With receive check on, received data is checked into result regs.
// - With transmit append on, the check value follows the packet data.
// - Length mode 00 is a one-byte field, 01 adds three upper length bits.
// - Transmit length comes from the length registers; done when all sent.
// - Receive length comes from received data; done when all received.
// - The configuration register resets to 0x1C.
// - Layout value 10 is the general-purpose layout allowing 8/32 widths.
`timescale 1ns/1ns
module pcl_engine #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst,
	// Register port.
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData_ff,
	// Host transmit data.
	input  wire logic       txWrValid,
	input  wire logic [7:0] txWrData,
	input  wire logic       txWrLast,
	output logic            txWrReady,
	// Transmit control and modem stream.
	input  wire logic       txStart,
	output logic            txOutValid_ff,
	output logic      [7:0] txOutData_ff,
	input  wire logic       txOutReady,
	output logic            txDone_ff,
	// Receive control and modem stream.
	input  wire logic       rxStart,
	input  wire logic       rxInValid,
	input  wire logic [7:0] rxInData,
	output logic            rxOutValid_ff,
	output logic      [7:0] rxOutData_ff,
	output logic            rxDone_ff
);
	localparam int LW = pcl_pkg::LEN_W;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_DATA  = 2'b01,
		TX_CHECK = 2'b10,
		TX_DONE  = 2'b11
	} pcl_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE   = 2'b00,
		RX_LEN_HI = 2'b01,
		RX_LEN_LO = 2'b10,
		RX_BODY   = 2'b11
	} pcl_rx_state_t;

	pcl_pkg::pcl_cfg_t cfg_ff;
	pcl_tx_state_t     txState_ff;
	pcl_rx_state_t     rxState_ff;
	logic [1:0]        layout_ff;
	logic [LW-1:0]     txLen_ff;
	logic [23:0]       result_ff;
	logic              accErr_ff;
	logic              rxErr_ff;
	logic              accErrSet_ff;
	logic              rxErrSet_ff;

	logic [1:0]        effWidth;
	logic [5:0]        nBits;
	logic [2:0]        nBytes;
	logic [31:0]       poly;
	logic [31:0]       topMask;
	logic [31:0]       rightMask;
	logic [31:0]       seed;
	logic [31:0]       compMask;

	assign effWidth = pcl_pkg::pcl_eff_width(cfg_ff.checkWidthSelect,
		layout_ff);
	assign nBits = pcl_pkg::pcl_bits(effWidth);
	assign nBytes = nBits[5:3];
	assign poly = pcl_pkg::pcl_poly(effWidth);
	assign rightMask = {32{1'b1}} >> (pcl_pkg::CRC_MAX - nBits);
	assign topMask = ~({32{1'b1}} >> nBits);
	assign seed = cfg_ff.seedOnes ? topMask : '0;
	assign compMask = cfg_ff.compOff ? '0 : topMask;

	// Transmit FIFO between the host and the transmit engine.
	logic       fifoOutValid;
	logic [7:0] fifoOutData;
	logic       fifoOutReady;

	pcl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) txFifo (
		.clock    (clock),
		.rst      (rst),
		.inValid  (txWrValid),
		.inData   (txWrData),
		.inReady  (txWrReady),
		.outValid (fifoOutValid),
		.outData  (fifoOutData),
		.outReady (fifoOutReady)
	);

	// Register writes, reads and sticky status.
	logic [7:0] status;
	assign status = {4'h0, rxState_ff != RX_IDLE, txState_ff != TX_IDLE,
		rxErr_ff, accErr_ff};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_ff    <= pcl_pkg::CFG_RESET;
			layout_ff <= pcl_pkg::LAYOUT_RESET;
			txLen_ff  <= '0;
		end else if (regWrEn) begin
			case (regAddr)
				pcl_pkg::ADDR_CFG:     cfg_ff <= regWrData;
				pcl_pkg::ADDR_LAYOUT:  layout_ff <= regWrData[1:0];
				pcl_pkg::ADDR_TXLEN_H:
					txLen_ff[LW-1:8] <= regWrData[pcl_pkg::LEN_HI_BITS-1:0];
				pcl_pkg::ADDR_TXLEN_L: txLen_ff[7:0] <= regWrData;
				default: ;
			endcase
		end
	end

	// A set arriving with a write-one-to-clear wins.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			accErr_ff <= 1'b0;
			rxErr_ff  <= 1'b0;
		end else begin
			if (accErrSet_ff)
				accErr_ff <= 1'b1;
			else if (regWrEn && regAddr == pcl_pkg::ADDR_STATUS &&
					regWrData[pcl_pkg::ST_ACC_ERR])
				accErr_ff <= 1'b0;
			if (rxErrSet_ff)
				rxErr_ff <= 1'b1;
			else if (regWrEn && regAddr == pcl_pkg::ADDR_STATUS &&
					regWrData[pcl_pkg::ST_RX_ERR])
				rxErr_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdData_ff <= '0;
		end else if (regRdEn) begin
			case (regAddr)
				pcl_pkg::ADDR_CFG:     regRdData_ff <= cfg_ff;
				pcl_pkg::ADDR_LAYOUT:  regRdData_ff <= {6'h0, layout_ff};
				pcl_pkg::ADDR_TXLEN_H: regRdData_ff <= {5'h0, txLen_ff[LW-1:8]};
				pcl_pkg::ADDR_TXLEN_L: regRdData_ff <= txLen_ff[7:0];
				pcl_pkg::ADDR_RES_H:   regRdData_ff <= result_ff[23:16];
				pcl_pkg::ADDR_RES_M:   regRdData_ff <= result_ff[15:8];
				pcl_pkg::ADDR_RES_L:   regRdData_ff <= result_ff[7:0];
				pcl_pkg::ADDR_STATUS:  regRdData_ff <= status;
				default:               regRdData_ff <= '0;
			endcase
		end
	end

	// Host write portions, watched for a too-short final portion.
	logic [LW:0] wrTotal_ff;
	logic [LW:0] portion_ff;
	logic        laterPortion_ff;
	logic        wrTake;
	assign wrTake = txWrValid && txWrReady;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrTotal_ff      <= '0;
			portion_ff      <= '0;
			laterPortion_ff <= 1'b0;
			accErrSet_ff    <= 1'b0;
		end else begin
			accErrSet_ff <= 1'b0;
			if (wrTake && txWrLast) begin
				portion_ff <= '0;
				if (wrTotal_ff + 1'b1 >= {1'b0, txLen_ff}) begin
					wrTotal_ff      <= '0;
					laterPortion_ff <= 1'b0;
					accErrSet_ff    <= !cfg_ff.txAppendEn && laterPortion_ff &&
						(portion_ff + 1'b1 <= (LW + 1)'(nBytes));
				end else begin
					wrTotal_ff      <= wrTotal_ff + 1'b1;
					laterPortion_ff <= 1'b1;
				end
			end else if (wrTake) begin
				wrTotal_ff <= wrTotal_ff + 1'b1;
				portion_ff <= portion_ff + 1'b1;
			end
		end
	end

	// Transmit engine.
	logic [LW-1:0] txRemain_ff;
	logic [31:0]   txCrc_ff;
	logic [2:0]    txIdx_ff;
	logic          txSlot;
	logic [31:0]   txChkWord;

	assign txSlot = !txOutValid_ff || txOutReady;
	assign fifoOutReady = txState_ff == TX_DATA && txSlot && txRemain_ff != '0;
	assign txChkWord = (txCrc_ff ^ compMask) << {txIdx_ff, 3'h0};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			txState_ff    <= TX_IDLE;
			txRemain_ff   <= '0;
			txCrc_ff      <= '0;
			txIdx_ff      <= '0;
			txOutValid_ff <= 1'b0;
			txOutData_ff  <= '0;
			txDone_ff     <= 1'b0;
		end else begin
			txDone_ff <= 1'b0;
			if (txOutReady)
				txOutValid_ff <= 1'b0;
			case (txState_ff)
				TX_IDLE: if (txStart) begin
					txRemain_ff <= txLen_ff;
					txCrc_ff    <= seed;
					txIdx_ff    <= '0;
					if (txLen_ff != '0)
						txState_ff <= TX_DATA;
					else
						txState_ff <= cfg_ff.txAppendEn ? TX_CHECK : TX_DONE;
				end
				TX_DATA: if (fifoOutReady && fifoOutValid) begin
					txOutValid_ff <= 1'b1;
					txOutData_ff  <= fifoOutData;
					txCrc_ff      <= pcl_pkg::pcl_crc_byte(txCrc_ff, fifoOutData, poly);
					txRemain_ff   <= txRemain_ff - 1'b1;
					if (txRemain_ff == LW'(1))
						txState_ff <= cfg_ff.txAppendEn ? TX_CHECK : TX_DONE;
				end
				TX_CHECK: if (txSlot) begin
					txOutValid_ff <= 1'b1;
					txOutData_ff  <= txChkWord[31:24];
					txIdx_ff      <= txIdx_ff + 1'b1;
					if (txIdx_ff + 1'b1 == nBytes)
						txState_ff <= TX_DONE;
				end
				TX_DONE: if (txSlot) begin
					txDone_ff  <= 1'b1;
					txState_ff <= TX_IDLE;
				end
				default: txState_ff <= TX_IDLE;
			endcase
		end
	end

	// Receive engine.
	logic [LW-1:0] rxRemain_ff;
	logic [2:0]    rxLenHi_ff;
	logic [31:0]   rxCrc_ff;
	logic [31:0]   rxCheck_ff;
	logic [31:0]   rxFinal;
	logic [LW-1:0] rxLenNew;
	logic          rxIsCheck;

	assign rxFinal = (rxCrc_ff ^ compMask) >> (pcl_pkg::CRC_MAX - nBits);
	assign rxLenNew = (cfg_ff.lenMode == pcl_pkg::LEN_MODE_2) ?
		{rxLenHi_ff, rxInData} : {3'h0, rxInData};
	assign rxIsCheck = cfg_ff.rxCheckEn &&
		rxRemain_ff <= LW'(nBytes);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxOutValid_ff <= 1'b0;
			rxOutData_ff  <= '0;
		end else begin
			rxOutValid_ff <= rxInValid && rxState_ff != RX_IDLE;
			rxOutData_ff  <= rxInData;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rxState_ff  <= RX_IDLE;
			rxRemain_ff <= '0;
			rxLenHi_ff  <= '0;
			rxCrc_ff    <= '0;
			rxCheck_ff  <= '0;
			rxDone_ff   <= 1'b0;
			rxErrSet_ff <= 1'b0;
			result_ff   <= '0;
		end else begin
			rxDone_ff   <= 1'b0;
			rxErrSet_ff <= 1'b0;
			case (rxState_ff)
				RX_IDLE: if (rxStart) begin
					rxCrc_ff   <= seed;
					rxCheck_ff <= '0;
					rxState_ff <= (cfg_ff.lenMode == pcl_pkg::LEN_MODE_2) ?
						RX_LEN_HI : RX_LEN_LO;
				end
				RX_LEN_HI: if (rxInValid) begin
					rxLenHi_ff <= rxInData[pcl_pkg::LEN_HI_BITS-1:0];
					rxCrc_ff   <= pcl_pkg::pcl_crc_byte(rxCrc_ff, rxInData, poly);
					rxState_ff <= RX_LEN_LO;
				end
				RX_LEN_LO: if (rxInValid) begin
					rxRemain_ff <= rxLenNew;
					rxCrc_ff    <= pcl_pkg::pcl_crc_byte(rxCrc_ff, rxInData, poly);
					if (rxLenNew != '0) begin
						rxState_ff <= RX_BODY;
					end else begin
						rxDone_ff  <= 1'b1;
						rxState_ff <= RX_IDLE;
					end
				end
				RX_BODY: if (rxInValid) begin
					rxRemain_ff <= rxRemain_ff - 1'b1;
					if (rxIsCheck)
						rxCheck_ff <= {rxCheck_ff[23:0], rxInData};
					else
						rxCrc_ff <= pcl_pkg::pcl_crc_byte(rxCrc_ff, rxInData, poly);
					if (rxRemain_ff == LW'(1)) begin
						rxDone_ff  <= 1'b1;
						rxState_ff <= RX_IDLE;
						if (cfg_ff.rxCheckEn) begin
							result_ff   <= rxFinal[23:0];
							rxErrSet_ff <= ({rxCheck_ff[23:0], rxInData} &
								rightMask) != rxFinal;
						end
					end
				end
				default: rxState_ff <= RX_IDLE;
			endcase
		end
	end
endmodule

// [dv/pcl_engine_assertions.sv]
// Concurrent checks on the packet engine's ports.
// Assumes one clock domain with rst as its asynchronous reset.
`timescale 1ns/1ns
module pcl_engine_assertions (
	// Clock and reset.
	input wire logic       clock,
	input wire logic       rst,
	// Register port.
	input wire logic [7:0] regAddr,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData_ff,
	// Transmit stream.
	input wire logic       txOutValid_ff,
	input wire logic [7:0] txOutData_ff,
	input wire logic       txOutReady,
	input wire logic       txDone_ff,
	// Receive stream.
	input wire logic       rxInValid,
	input wire logic [7:0] rxInData,
	input wire logic       rxOutValid_ff,
	input wire logic [7:0] rxOutData_ff,
	input wire logic       rxDone_ff
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence sTxStall;
		txOutValid_ff && !txOutReady;
	endsequence
	sequence sRdIdle;
		!regRdEn;
	endsequence
	AST_TX_HOLD: assert property (sTxStall |=> txOutValid_ff
		&& $stable(txOutData_ff)) else $error("tx byte lost in stall");
	AST_TX_DONE_PULSE: assert property (txDone_ff |=> !txDone_ff)
		else $error("tx done longer than one cycle");
	AST_TX_DONE_QUIET: assert property (txDone_ff |-> !txOutValid_ff)
		else $error("tx done with byte pending");
	AST_RX_DONE_PULSE: assert property (rxDone_ff |=> !rxDone_ff)
		else $error("rx done longer than one cycle");
	AST_RX_DONE_CAUSE: assert property (rxDone_ff |-> $past(rxInValid))
		else $error("rx done without a byte");
	AST_RX_COPY: assert property (rxOutValid_ff |-> $past(rxInValid)
		&& rxOutData_ff == $past(rxInData)) else $error("rx copy wrong");
	AST_RD_HOLD: assert property (sRdIdle |=> $stable(regRdData_ff))
		else $error("read data moved without a read");
	AST_RD_UNMAPPED: assert property (regRdEn && regAddr == 8'h00
		|=> ##[0:1] regRdData_ff == 8'h00) else $error("unmapped read");
endmodule

bind pcl_engine pcl_engine_assertions u_sva (.clock, .rst, .regAddr,
	.regRdEn, .regRdData_ff, .txOutValid_ff, .txOutData_ff, .txOutReady,
	.txDone_ff, .rxInValid, .rxInData, .rxOutValid_ff, .rxOutData_ff,
	.rxDone_ff);

// [dv/pcl_modem_model.sv]
// Modem side model: takes transmit bytes with random stalls, sends rx bytes.
// Assumes the engine's clock; drives its outputs at the falling edge.
`timescale 1ns/1ns
module pcl_modem_model (
	// Clock.
	input wire logic       clock,
	// Transmit stream.
	input wire logic       txOutValid_ff,
	input wire logic [7:0] txOutData_ff,
	output logic           txOutReady,
	// Receive stream.
	output logic           rxInValid,
	output logic     [7:0] rxInData
);
	logic [7:0] txQ[$];
	int         stallPct = 20;
	initial begin
		txOutReady = 1'h0;
		rxInValid = 1'h0;
		rxInData = 8'h00;
	end
	always @(negedge clock) begin
		txOutReady <= ($urandom % 100) >= stallPct;
	end
	always @(posedge clock) begin
		if (txOutValid_ff && txOutReady)
			txQ.push_back(txOutData_ff);
	end
	// Idle data shows the inverse so a stale byte is never mistaken.
	task automatic sendRx(input logic [7:0] d);
		@(negedge clock);
		rxInValid = 1'h1;
		rxInData = d;
		@(negedge clock);
		rxInValid = 1'h0;
		rxInData = ~d;
	endtask
endmodule

// [dv/pcl_engine_tb_top.sv]
// Self-checking bench for the packet check-sequence and length engine.
// Assumes the modem model on the stream side; host driven from here.
`timescale 1ns/1ns
module pcl_engine_tb_top;
	logic clock = 1'h0, rst = 1'h1, regWrEn = 1'h0, regRdEn = 1'h0;
	logic txWrValid = 1'h0, txWrLast = 1'h0, txStart = 1'h0, rxStart = 1'h0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, txWrData = 8'h00;
	logic [7:0] regRdData_ff, txOutData_ff, rxInData, rxOutData_ff;
	logic txWrReady, txOutValid_ff, txOutReady, txDone_ff, rxInValid;
	logic rxOutValid_ff, rxDone_ff;
	int miscompares = 0, cmp_count = 0;
	int tw[6] = '{0, 1, 2, 0, 1, 2}, tl[6] = '{2, 2, 2, 0, 2, 2};
	int ta[6] = '{1, 1, 1, 1, 0, 0}, tn[6] = '{4, 1, 20, 3, 5, 7};
	int ts[6] = '{4, 1, 20, 3, 3, 2}, rl[3] = '{0, 1, 0};
	int rc[3] = '{1, 1, 0}, rn[3] = '{3, 256, 2}, rx[3] = '{0, 1, 1};

	pcl_engine #(.FIFO_DEPTH(16)) uut (.clock, .rst, .regAddr, .regWrEn,
		.regWrData, .regRdEn, .regRdData_ff, .txWrValid, .txWrData,
		.txWrLast, .txWrReady, .txStart, .txOutValid_ff, .txOutData_ff,
		.txOutReady, .txDone_ff, .rxStart, .rxInValid, .rxInData,
		.rxOutValid_ff, .rxOutData_ff, .rxDone_ff);
	pcl_modem_model m (.clock, .txOutValid_ff, .txOutData_ff, .txOutReady,
		.rxInValid, .rxInData);

	function automatic logic [31:0] crcOf(input logic [7:0] q[$],
			input int nb, input logic so, input logic co);
		logic [31:0] c, p;
		p = nb == 1 ? {pcl_pkg::POLY8, 24'h0} : nb == 2 ?
			{pcl_pkg::POLY16, 16'h0} : pcl_pkg::POLY32;
		c = so ? ~(32'hffffffff >> (8 * nb)) : 32'h0;
		foreach (q[i]) begin
			c ^= {q[i], 24'h0};
			repeat (8) c = c[31] ? (c << 1) ^ p : c << 1;
		end
		c = c >> (32 - 8 * nb);
		return co ? c : c ^ (32'hffffffff >> (32 - 8 * nb));
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'h1;
		@(negedge clock);
		regWrEn = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regRdEn = 1'h1;
		@(negedge clock);
		regRdEn = 1'h0;
		@(negedge clock);
		d = regRdData_ff;
	endtask
	task automatic pulse(input bit isRx);
		@(negedge clock);
		if (isRx)
			rxStart = 1'h1;
		else
			txStart = 1'h1;
		@(negedge clock);
		rxStart = 1'h0;
		txStart = 1'h0;
	endtask
	task automatic push(input logic [7:0] d, input logic l);
		txWrValid = 1'h1;
		txWrData = d;
		txWrLast = l;
		while (txWrReady !== 1'h1)
			@(negedge clock);
		@(negedge clock);
	endtask
	task automatic waitDone(input bit isRx, input bit must);
		int k;
		// Looks before waiting: the one-cycle pulse may already stand.
		for (k = 0; k < 3000; k++) begin
			if ((isRx ? rxDone_ff : txDone_ff) === 1'h1)
				break;
			@(negedge clock);
		end
		if (must)
			chk(k < 3000, 1'h1);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		forever #5 clock = ~clock;
	end
	initial begin
		#300000;
		miscompares++;
		wrap_up;
	end
	initial begin
		logic [7:0] d, r;
		logic [7:0] q[$], ex[$];
		logic [31:0] c;
		logic [10:0] ln;
		logic so, co, ee;
		int nb;
		void'($urandom(32'hccb2));
		repeat (12) @(negedge clock);
		rst = 1'h0;
		rd(pcl_pkg::ADDR_CFG, d);
		chk(d, 8'h1c);
		rd(8'h00, d);
		chk(d, 8'h00);
		r = 8'($urandom) & 8'hdf;
		wr(pcl_pkg::ADDR_CFG, r);
		rd(pcl_pkg::ADDR_CFG, d);
		chk(d, r);
		for (int e = 0; e < 6; e++) begin
			so = 1'($urandom);
			co = 1'($urandom);
			nb = (tl[e] == 2 || tw[e] == 1) ? 1 << tw[e] : 2;
			ee = !ta[e] && ts[e] < tn[e] && tn[e] - ts[e] <= nb;
			wr(pcl_pkg::ADDR_LAYOUT, 8'(tl[e]));
			wr(pcl_pkg::ADDR_CFG, {so, co, 2'(tw[e]), 1'h1, 1'(ta[e]), 2'h0});
			wr(pcl_pkg::ADDR_TXLEN_H, 8'(tn[e] >> 8));
			wr(pcl_pkg::ADDR_TXLEN_L, 8'(tn[e]));
			q = {};
			repeat (tn[e]) q.push_back(8'($urandom));
			ex = q;
			c = crcOf(q, nb, so, co);
			if (ta[e])
				for (int i = nb - 1; i >= 0; i--) ex.push_back(c[8*i +: 8]);
			m.stallPct = tn[e] > 16 ? 60 : 20;
			m.txQ = {};
			fork
				begin
					foreach (q[i]) push(q[i], i == ts[e] - 1 || i == tn[e] - 1);
					txWrValid = 1'h0;
				end
				begin
					repeat (25) @(negedge clock);
					pulse(0);
				end
			join
			waitDone(0, !ee);
			rd(pcl_pkg::ADDR_STATUS, d);
			chk(d[pcl_pkg::ST_ACC_ERR], ee);
			if (!ee) begin
				chk(m.txQ.size(), ex.size());
				foreach (ex[i]) chk(m.txQ[i], ex[i]);
			end
			wr(pcl_pkg::ADDR_STATUS, 8'h03);
		end
		for (int e = 0; e < 3; e++) begin
			so = 1'($urandom);
			co = 1'($urandom);
			ln = 11'(rn[e] + 2);
			wr(pcl_pkg::ADDR_LAYOUT, 8'h00);
			wr(pcl_pkg::ADDR_CFG, {so, co, 2'h1, 1'(rc[e]), 1'h1, 2'(rl[e])});
			q = {};
			if (rl[e])
				q.push_back({5'h00, ln[10:8]});
			q.push_back(ln[7:0]);
			repeat (rn[e]) q.push_back(8'($urandom));
			c = crcOf(q, 2, so, co);
			q.push_back(c[15:8] ^ 8'(rx[e]));
			q.push_back(c[7:0]);
			pulse(1);
			foreach (q[i]) m.sendRx(q[i]);
			waitDone(1, 1);
			rd(pcl_pkg::ADDR_STATUS, d);
			chk(d[pcl_pkg::ST_RX_ERR], rc[e] & rx[e]);
			if (rc[e]) begin
				rd(pcl_pkg::ADDR_RES_M, d);
				chk(d, c[15:8]);
				rd(pcl_pkg::ADDR_RES_L, d);
				chk(d, c[7:0]);
			end
			wr(pcl_pkg::ADDR_STATUS, 8'h03);
		end
		wrap_up;
	end
endmodule
